//--- hdl/credit_demux_pkg.sv
// Shared constants and helpers for the credit stream demultiplexer ends.
package credit_demux_pkg;
  // Default build settings.
  localparam int NUM_SINK_DEF = 4;
  localparam int SYMBOLS_DEF = 4;
  localparam int SYMBOL_W_DEF = 8;
  localparam int CHAN_W_DEF = 8;
  localparam int ERR_W_DEF = 1;
  localparam int EMPTY_W_DEF = 2;
  localparam int SINK_MAX_CREDIT_DEF = 16;
  localparam int SRC_MAX_CREDIT_DEF = 16;
  localparam int FIFO_DEPTH_DEF = 16;
  // Legal credit limit range.
  localparam int CREDIT_MIN = 1;
  localparam int CREDIT_MAX = 256;
  // Width of an optional field on a port; an absent field keeps one tied-off bit.
  function automatic int port_w(input int use_it, input int w);
    return (use_it != 0 && w > 0) ? w : 1;
  endfunction
  // Steering bits needed to address every sink.
  function automatic int sel_w(input int n);
    return (n > 1) ? $clog2(n) : 1;
  endfunction
  // True when a credit limit is a power of two within the legal range.
  function automatic bit credit_ok(input int c);
    return c >= CREDIT_MIN && c <= CREDIT_MAX && (c & (c - 1)) == 0;
  endfunction
  // Packet tracking states of the source end.
  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_PKT = 2'h2
  } pkt_state_t;
endpackage

//--- hdl/credit_stream_if.sv
// Link between the upstream credit source and the demultiplexer.
`timescale 1ns/1ps
`default_nettype none
interface credit_stream_if #(
  parameter int DATA_W = 32,
  parameter int CHAN_W = 8,
  parameter int EMPTY_PW = 2,
  parameter int ERR_PW = 1
);
  logic valid;
  logic [DATA_W-1:0] data;
  logic [CHAN_W-1:0] chan;
  logic sop;
  logic eop;
  logic [EMPTY_PW-1:0] empty;
  logic [ERR_PW-1:0] err;
  logic credit;
  // Source end drives beats and takes credits back.
  modport src (output valid, data, chan, sop, eop, empty, err, input credit);
  // Demultiplexer end takes beats and returns one credit per pulse.
  modport dmx (input valid, data, chan, sop, eop, empty, err, output credit);
endinterface
`default_nettype wire

//--- hdl/credit_stream_demux.sv
// Credit demultiplexer end with its input FIFO.
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Simple FIFO with valid and ready on both sides.
module stream_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Fill side.
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  // Drain side.
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [CW-1:0] count_reg;
  logic push;
  logic pop;

  // Full and empty follow the occupancy count exactly.
  assign o_ready = count_reg != CW'(DEPTH);
  assign o_valid = count_reg != '0;
  assign o_data = mem[rd_reg];
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;

  // Storage has no reset; only the pointers define contents.
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_reg] <= i_data;
    end
  end

  // Pointers wrap at the depth, which need not be a power of two.
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
      end
    end
  end

  // Occupancy.
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      count_reg <= '0;
    end else if (push && !pop) begin
      count_reg <= count_reg + 1'b1;
    end else if (pop && !push) begin
      count_reg <= count_reg - 1'b1;
    end
  end
endmodule // stream_fifo

////////////////////////////////////////////////////////////////////////////////
// What this block does
// - Source always supplies the channel steering field.
// - Channel wide enough to address every sink.
// - Route by low channel bits, ignore upper.
// - Source keeps packets whole; no reassembly here.
// - Steering bits stay constant within a packet.
// - Sink credit limit: power of two, 1-256.
// - Symbols and symbol width 1-1024 each.
// - Channel width 1-128, moot without channel.
// - Error width to 1024; zero means absent. Here a zero width with USE_ERROR set still carries one error bit.
// - Empty width to 1024; zero means absent. Here a zero width with empty enabled still carries one bit.
// - Packet mode carries start, end, empty along.
module credit_stream_demux
  import credit_demux_pkg::*;
#(
  parameter int NUM_SINK = NUM_SINK_DEF,
  parameter int SYMBOLS = SYMBOLS_DEF,
  parameter int SYMBOL_W = SYMBOL_W_DEF,
  parameter int CHAN_W = CHAN_W_DEF,
  parameter int ERR_W = ERR_W_DEF,
  parameter int EMPTY_W = EMPTY_W_DEF,
  parameter int USE_PACKETS = 1,
  parameter int USE_EMPTY = 1,
  parameter int USE_ERROR = 1,
  parameter int SINK_MAX_CREDIT = SINK_MAX_CREDIT_DEF,
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Upstream credit link.
  credit_stream_if.dmx up,
  // Downstream credit returns, one pulse per credit.
  input wire logic [NUM_SINK-1:0] i_sink_credit,
  // Downstream beats, shared payload with one valid per sink.
  output logic [NUM_SINK-1:0] o_sink_valid,
  output logic [SYMBOLS*SYMBOL_W-1:0] o_data,
  output logic [CHAN_W-1:0] o_chan,
  output logic o_sop,
  output logic o_eop,
  output logic [port_w(USE_EMPTY * USE_PACKETS, EMPTY_W)-1:0] o_empty,
  output logic [port_w(USE_ERROR, ERR_W)-1:0] o_err
);
  localparam int DATA_W = SYMBOLS * SYMBOL_W;
  localparam int EMP_PW = port_w(USE_EMPTY * USE_PACKETS, EMPTY_W);
  localparam int ERR_PW = port_w(USE_ERROR, ERR_W);
  localparam int SEL_W = sel_w(NUM_SINK);
  localparam bit SINK_CREDIT_LEGAL = credit_ok(SINK_MAX_CREDIT);
  localparam int CRD_W = $clog2(SINK_MAX_CREDIT) + 1;
  localparam int OWE_W = $clog2(FIFO_DEPTH + 1);
  localparam int PW = 2 + EMP_PW + ERR_PW + CHAN_W + DATA_W;
  localparam int CHAN_LO = DATA_W;
  localparam int ERR_LO = CHAN_LO + CHAN_W;
  localparam int EMP_LO = ERR_LO + ERR_PW;
  localparam int EOP_BIT = EMP_LO + EMP_PW;
  localparam int SOP_BIT = EOP_BIT + 1;

  logic [PW-1:0] in_word;
  logic [PW-1:0] head;
  logic f_in_ready;
  logic f_out_valid;
  logic take;
  logic route_ok;
  logic [SEL_W-1:0] sel;
  logic [NUM_SINK-1:0] has_credit;
  logic [NUM_SINK-1:0] spend;
  logic [OWE_W-1:0] owed_reg;
  logic credit_reg;
  logic [NUM_SINK-1:0] valid_reg;
  logic [DATA_W-1:0] data_reg;
  logic [CHAN_W-1:0] chan_reg;
  logic sop_reg;
  logic eop_reg;
  logic [EMP_PW-1:0] empty_reg;
  logic [ERR_PW-1:0] err_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Input packing; disabled options enter the FIFO as zero.
  // packet fields carried
  assign in_word = {(USE_PACKETS != 0) && up.sop, (USE_PACKETS != 0) && up.eop,
                    (EMP_PW)'((USE_EMPTY * USE_PACKETS != 0) ? up.empty : '0),
                    (ERR_PW)'((USE_ERROR != 0) ? up.err : '0),
                    up.chan, up.data};

  // The FIFO absorbs beats the source already holds credit for.
  stream_fifo #(
    .WIDTH(PW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_valid(up.valid),
    .o_ready(f_in_ready),
    .i_data(in_word),
    .o_valid(f_out_valid),
    .i_ready(take),
    .o_data(head)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Upstream credits: each FIFO slot is granted once, and again when it drains.
  // Granting only while the FIFO has room keeps the source from overrunning it.
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      owed_reg <= OWE_W'(FIFO_DEPTH);
      credit_reg <= 1'b0;
    end else begin
      credit_reg <= (owed_reg != '0) && f_in_ready;
      owed_reg <= owed_reg + OWE_W'(take)
                  - OWE_W'((owed_reg != '0) && f_in_ready);
    end
  end
  assign up.credit = credit_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Steering from the head of the FIFO.
  // channel always used
  assign sel = head[CHAN_LO +: SEL_W];
  assign route_ok = 32'(sel) < NUM_SINK;
  assign take = f_out_valid && SINK_CREDIT_LEGAL
                && (!route_ok || has_credit[sel]);

  // One credit counter per sink, saturating at the limit.
  genvar g;
  generate
    for (g = 0; g < NUM_SINK; g++) begin : g_sink
      logic [CRD_W-1:0] crd_reg;
      assign spend[g] = take && route_ok && (sel == SEL_W'(g));
      assign has_credit[g] = crd_reg != '0;
      always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
          crd_reg <= '0;
        end else if (i_sink_credit[g] && !spend[g]) begin
          if (crd_reg != CRD_W'(SINK_MAX_CREDIT)) begin
            crd_reg <= crd_reg + 1'b1;
          end
        end else if (spend[g] && !i_sink_credit[g]) begin
          crd_reg <= crd_reg - 1'b1;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Registered downstream beat; valid lasts one cycle per forwarded beat.
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      valid_reg <= '0;
    end else begin
      valid_reg <= spend;
    end
  end

  // Payload is held from the last forwarded beat.
  // forward packet fields
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      data_reg <= '0;
      chan_reg <= '0;
      sop_reg <= 1'b0;
      eop_reg <= 1'b0;
      empty_reg <= '0;
      err_reg <= '0;
    end else if (take && route_ok) begin
      data_reg <= head[DATA_W-1:0];
      chan_reg <= head[CHAN_LO +: CHAN_W];
      err_reg <= head[ERR_LO +: ERR_PW];
      empty_reg <= head[EMP_LO +: EMP_PW];
      eop_reg <= head[EOP_BIT];
      sop_reg <= head[SOP_BIT];
    end
  end

  assign o_sink_valid = valid_reg;
  assign o_data = data_reg;
  assign o_chan = chan_reg;
  assign o_sop = sop_reg;
  assign o_eop = eop_reg;
  assign o_empty = empty_reg;
  assign o_err = err_reg;
endmodule // credit_stream_demux
`default_nettype wire

//--- hdl/credit_stream_source.sv
// Upstream credit source end feeding the demultiplexer.
`timescale 1ns/1ps
`default_nettype none
module credit_stream_source
  import credit_demux_pkg::*;
#(
  parameter int NUM_SINK = NUM_SINK_DEF,
  parameter int SYMBOLS = SYMBOLS_DEF,
  parameter int SYMBOL_W = SYMBOL_W_DEF,
  parameter int CHAN_W = CHAN_W_DEF,
  parameter int ERR_W = ERR_W_DEF,
  parameter int EMPTY_W = EMPTY_W_DEF,
  parameter int USE_PACKETS = 1,
  parameter int USE_EMPTY = 1,
  parameter int USE_ERROR = 1,
  parameter int SRC_MAX_CREDIT = SRC_MAX_CREDIT_DEF
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // User beats in, ready/valid.
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [SYMBOLS*SYMBOL_W-1:0] i_data,
  input wire logic [CHAN_W-1:0] i_chan,
  input wire logic i_sop,
  input wire logic i_eop,
  input wire logic [port_w(USE_EMPTY * USE_PACKETS, EMPTY_W)-1:0] i_empty,
  input wire logic [port_w(USE_ERROR, ERR_W)-1:0] i_err,
  // Credit link toward the demultiplexer.
  credit_stream_if.src dn
);
  localparam int DATA_W = SYMBOLS * SYMBOL_W;
  localparam int EMP_PW = port_w(USE_EMPTY * USE_PACKETS, EMPTY_W);
  localparam int ERR_PW = port_w(USE_ERROR, ERR_W);
  localparam int SEL_W = sel_w(NUM_SINK);
  localparam int CRD_W = $clog2(SRC_MAX_CREDIT) + 1;

  logic [CRD_W-1:0] crd_reg;
  logic [CRD_W-1:0] crd_next;
  logic ready_reg;
  logic send;
  pkt_state_t state_reg;
  logic [SEL_W-1:0] lock_reg;
  logic [CHAN_W-1:0] chan_out;
  logic valid_reg;
  logic [DATA_W-1:0] data_reg;
  logic [CHAN_W-1:0] chan_reg;
  logic sop_reg;
  logic eop_reg;
  logic [EMP_PW-1:0] empty_reg;
  logic [ERR_PW-1:0] err_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Credits held; ready is registered so it equals "credit on hand".
  assign send = i_valid && ready_reg;
  always_comb begin
    crd_next = crd_reg;
    if (dn.credit && crd_reg != CRD_W'(SRC_MAX_CREDIT)) begin
      crd_next = crd_next + 1'b1;
    end
    if (send) begin
      crd_next = crd_next - 1'b1;
    end
  end
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      crd_reg <= '0;
      ready_reg <= 1'b0;
    end else begin
      crd_reg <= crd_next;
      ready_reg <= crd_next != '0;
    end
  end
  assign o_ready = ready_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Packet tracking locks the steering bits from start to end of a packet,
  // so a user slip cannot split one packet across two sinks.
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_reg <= ST_IDLE;
      lock_reg <= '0;
    end else if (send && USE_PACKETS != 0) begin
      unique case (state_reg)
        ST_IDLE: begin
          if (i_sop && !i_eop) begin
            state_reg <= ST_PKT;
            lock_reg <= i_chan[SEL_W-1:0];
          end
        end
        ST_PKT: begin
          if (i_eop) begin
            state_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

  always_comb begin
    chan_out = i_chan;
    if (state_reg == ST_PKT) begin
      chan_out[SEL_W-1:0] = lock_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link beat registers; valid lasts one cycle per beat sent.
  // channel always driven
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      valid_reg <= 1'b0;
      data_reg <= '0;
      chan_reg <= '0;
      sop_reg <= 1'b0;
      eop_reg <= 1'b0;
      empty_reg <= '0;
      err_reg <= '0;
    end else begin
      valid_reg <= send;
      if (send) begin
        data_reg <= i_data;
        chan_reg <= chan_out;
        sop_reg <= (USE_PACKETS != 0) && i_sop;
        eop_reg <= (USE_PACKETS != 0) && i_eop;
        empty_reg <= (USE_EMPTY * USE_PACKETS != 0) ? i_empty : '0;
        err_reg <= (USE_ERROR != 0) ? i_err : '0;
      end
    end
  end

  assign dn.valid = valid_reg;
  assign dn.data = data_reg;
  assign dn.chan = chan_reg;
  assign dn.sop = sop_reg;
  assign dn.eop = eop_reg;
  assign dn.empty = empty_reg;
  assign dn.err = err_reg;
endmodule // credit_stream_source
`default_nettype wire

//--- dv/credit_link_asserts.sv
// Protocol checker for the credit link between source and demultiplexer.
`timescale 1ns/1ps
`default_nettype none
module credit_link_asserts #(
  parameter int CHAN_W = 8,
  parameter int SEL_W = 2,
  parameter int MAX_CRD = 16
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Link signals.
  input wire logic valid,
  input wire logic [CHAN_W-1:0] chan,
  input wire logic sop,
  input wire logic eop,
  input wire logic credit
);
  int crd_reg;
  logic in_pkt_reg;
  logic [SEL_W-1:0] lock_reg;
  ////////////////////////////////////////////////////////////////////////////
  // Credits the source holds: returns seen minus beats sent.
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      crd_reg <= 0;
    end else begin
      crd_reg <= crd_reg + int'(credit) - int'(valid);
    end
  end
  // Packet framing and the steering bits locked at its first beat.
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      in_pkt_reg <= 1'h0;
      lock_reg <= '0;
    end else if (valid) begin
      in_pkt_reg <= sop ? !eop : (in_pkt_reg && !eop);
      if (sop) begin
        lock_reg <= chan[SEL_W-1:0];
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // The buffer grants its first eight slots back to back after reset.
  sequence s_grants;
    credit [*8];
  endsequence
  sequence s_quiet;
    !valid [*2];
  endsequence
  property p_send_credit; valid |-> crd_reg > 0; endproperty
  a_send_credit: assert property (p_send_credit) else $error("beat without credit");
  property p_crd_max; crd_reg <= MAX_CRD; endproperty
  a_crd_max: assert property (p_crd_max) else $error("credits over limit");
  property p_credit_room; credit |-> crd_reg < MAX_CRD; endproperty
  a_credit_room: assert property (p_credit_room) else $error("credit with no room");
  property p_rst_quiet; $fell(i_sys_rst) |-> s_quiet; endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("beat right after reset");
  property p_rst_grant; $fell(i_sys_rst) |-> ##[0:2] s_grants; endproperty
  a_rst_grant: assert property (p_rst_grant) else $error("slow credit grant");
  property p_sel_lock; valid && in_pkt_reg |-> chan[SEL_W-1:0] == lock_reg; endproperty
  a_sel_lock: assert property (p_sel_lock) else $error("steering changed in packet");
  property p_pkt_open; valid |-> (sop == !in_pkt_reg); endproperty
  a_pkt_open: assert property (p_pkt_open) else $error("packet start misplaced");
  property p_eop_close; valid && eop |=> !valid || sop; endproperty
  a_eop_close: assert property (p_eop_close) else $error("beat after end not a start");
endmodule // credit_link_asserts
`default_nettype wire

//--- dv/credit_stream_demultiplexer_test.sv
// Self-checking bench joining the credit source to the demultiplexer.
`timescale 1ns/1ps
`default_nettype none
module credit_stream_demultiplexer_test
  import credit_demux_pkg::*;
();
  localparam int DW = 32;
  logic i_clk = 1'h0;
  logic i_sys_rst = 1'h1;
  logic i_valid = 1'h0;
  logic o_ready;
  logic [DW-1:0] i_data = '0;
  logic [7:0] i_chan = '0;
  logic i_sop = 1'h0;
  logic i_eop = 1'h0;
  logic [1:0] i_empty = '0;
  logic [0:0] i_err = '0;
  logic [3:0] i_sink_credit = '0;
  logic [3:0] o_sink_valid;
  logic [DW-1:0] o_data;
  logic [7:0] o_chan;
  logic o_sop;
  logic o_eop;
  logic [1:0] o_empty;
  logic [0:0] o_err;
  logic [48:0] seen_q[$];
  int errors = 0;
  int checks_done = 0;
  ////////////////////////////////////////////////////////////////////////////
  // Link widths follow the package defaults that both ends are built with.
  credit_stream_if #(.DATA_W(DW), .CHAN_W(CHAN_W_DEF), .EMPTY_PW(port_w(1, EMPTY_W_DEF)),
    .ERR_PW(port_w(1, ERR_W_DEF))) credit_stream_if_i ();
  credit_stream_source credit_stream_source_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_valid(i_valid), .o_ready(o_ready), .i_data(i_data), .i_chan(i_chan), .i_sop(i_sop),
    .i_eop(i_eop), .i_empty(i_empty), .i_err(i_err), .dn(credit_stream_if_i.src));
  credit_stream_demux credit_stream_demux_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .up(credit_stream_if_i.dmx), .i_sink_credit(i_sink_credit), .o_sink_valid(o_sink_valid),
    .o_data(o_data), .o_chan(o_chan), .o_sop(o_sop), .o_eop(o_eop), .o_empty(o_empty),
    .o_err(o_err));
  credit_link_asserts #(.CHAN_W(CHAN_W_DEF), .SEL_W(sel_w(NUM_SINK_DEF)),
    .MAX_CRD(SRC_MAX_CREDIT_DEF)) credit_link_asserts_i (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .valid(credit_stream_if_i.valid),
    .chan(credit_stream_if_i.chan), .sop(credit_stream_if_i.sop),
    .eop(credit_stream_if_i.eop), .credit(credit_stream_if_i.credit));
  ////////////////////////////////////////////////////////////////////////////
  // Clock at 100 MHz and a collector of every beat handed to a sink.
  initial begin
    forever #5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    if (o_sink_valid !== 4'h0 && !i_sys_rst) begin
      seen_q.push_back({o_sink_valid, o_chan, o_sop, o_eop, o_empty, o_err, o_data});
    end
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Holds the beat until o_ready reads high after a clock edge, or 300 cycles pass; valid is left up for back to back beats.
  task automatic send(input logic [7:0] c, input logic s, input logic e, input logic [DW-1:0] d);
    int n;
    n = 0;
    i_valid <= 1'h1;
    i_chan <= c;
    i_sop <= s;
    i_eop <= e;
    i_data <= d;
    i_empty <= c[1:0];
    // Error follows channel bit 2, so it matches the end flag beside it only on the closing beats of the two-beat packets.
    i_err <= c[2];
    do begin
      @(posedge i_clk);
      n++;
    end while (o_ready !== 1'h1 && n < 300);
  endtask
  task automatic give(input int g, input int n);
    repeat (n) begin
      i_sink_credit <= 4'h1 << g;
      @(posedge i_clk);
    end
    i_sink_credit <= 4'h0;
    @(posedge i_clk);
  endtask
  task automatic expect_beat(input logic [3:0] g, input logic [7:0] c, input logic s,
                             input logic e, input logic [DW-1:0] d);
    int n;
    n = 0;
    while (seen_q.size() == 0 && n < 300) begin
      @(negedge i_clk);
      n++;
    end
    chk(seen_q.size() != 0 ? seen_q.pop_front() : 49'h0, {g, c, s, e, c[1:0], c[2], d});
  endtask
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Watchdog: the whole sequence needs well under two thousand cycles.
  initial begin
    #50us;
    errors++;
    print_verdict();
  end
  initial begin
    repeat (10) @(posedge i_clk);
    i_sys_rst <= 1'h0;
    repeat (20) @(posedge i_clk);
    // Nothing leaves before the sink returns a credit; upper channel bits do not steer.
    send(8'h11, 1'h1, 1'h1, 32'hCAFE0001);
    i_valid <= 1'h0;
    repeat (20) @(posedge i_clk);
    chk(seen_q.size(), 0);
    give(1, 1);
    expect_beat(4'h2, 8'h11, 1'h1, 1'h1, 32'hCAFE0001);
    // Two-beat packets to every sink carry start, end, empty and error along.
    for (int g = 0; g < 4; g++) begin
      give(g, 2);
      send(8'hA4 + 8'(g), 1'h1, 1'h0, 32'hA000 + DW'(g));
      send(8'hA4 + 8'(g), 1'h0, 1'h1, 32'hB000 + DW'(g));
      i_valid <= 1'h0;
      expect_beat(4'h1 << g, 8'hA4 + 8'(g), 1'h1, 1'h0, 32'hA000 + DW'(g));
      expect_beat(4'h1 << g, 8'hA4 + 8'(g), 1'h0, 1'h1, 32'hB000 + DW'(g));
    end
    // One credit lets exactly one beat through; the second waits for the next credit.
    give(0, 1);
    send(8'h40, 1'h1, 1'h1, 32'h0000D001);
    send(8'h40, 1'h1, 1'h1, 32'h0000D002);
    i_valid <= 1'h0;
    expect_beat(4'h1, 8'h40, 1'h1, 1'h1, 32'h0000D001);
    repeat (20) @(posedge i_clk);
    chk(seen_q.size(), 0);
    give(0, 1);
    expect_beat(4'h1, 8'h40, 1'h1, 1'h1, 32'h0000D002);
    // Fill the buffer until the source is refused, then drain it in order.
    repeat (30) @(posedge i_clk);
    for (int k = 0; k < 16; k++) begin
      send(8'h03, 1'h1, 1'h1, 32'h5000 + DW'(k));
    end
    i_valid <= 1'h0;
    repeat (10) @(posedge i_clk);
    chk(o_ready, 0);
    give(3, 10);
    give(3, 6);
    for (int k = 0; k < 16; k++) begin
      expect_beat(4'h8, 8'h03, 1'h1, 1'h1, 32'h5000 + DW'(k));
    end
    repeat (30) @(posedge i_clk);
    chk(o_ready, 1);
    // A mid-run reset must drop credits that a sink returned before it.
    give(2, 2);
    i_sys_rst <= 1'h1;
    repeat (10) @(posedge i_clk);
    i_sys_rst <= 1'h0;
    repeat (30) @(posedge i_clk);
    send(8'h02, 1'h1, 1'h1, 32'h0000E001);
    i_valid <= 1'h0;
    repeat (20) @(posedge i_clk);
    chk(seen_q.size(), 0);
    give(2, 1);
    expect_beat(4'h4, 8'h02, 1'h1, 1'h1, 32'h0000E001);
    print_verdict();
  end
endmodule // credit_stream_demultiplexer_test
`default_nettype wire
